// File: drc_regs.svh
`ifndef DRC_REGS_SVH
`define DRC_REGS_SVH

// Mode, channel control and transfer count register offsets
`define DRC_MODE_OFS        4'h0
`define DRC_CTRL_OFS        4'h4
`define DRC_XFER_OFS        4'h8

// Mode register field positions
`define DRC_ACK_EN_BIT      30
`define DRC_END_EN_BIT      29
`define DRC_RSVD_RW_BIT     28
`define DRC_SENSE_BIT       27
`define DRC_NRD_BIT         26
`define DRC_BUSY_BIT        23

// Control register field positions
`define DRC_TE_BIT          0
`define DRC_SINGLE_BIT      1
`define DRC_XCNT_LSB        8

// Reset values
`define DRC_MODE_RST        1'b0
`define DRC_XCNT_RST        16'h0000

// Cycles of one single transfer (bus access length)
`define DRC_CYCLE_LEN       4'h3

`endif

// File: drc_pkg.sv
package drc_pkg;

  typedef enum logic [1:0] {
    DRC_IDLE,
    DRC_XFER,
    DRC_DONE
  } drc_state_e;

  typedef logic [31:0] drc_word_t;

endpackage : drc_pkg

// File: drc_req_detect.sv
`timescale 1ns/1ps
`default_nettype none

module drc_req_detect
  import drc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Configuration
  input  wire logic enable,
  input  wire logic edge_mode,
  input  wire logic accept_ok,
  // Request pin and start
  input  wire logic req_n,
  input  wire logic start,
  // Result
  output logic      pending,
  output logic      armed
);

  logic enable_d;

  always_ff @(posedge clk) begin
    if (srst) enable_d <= 1'b0;
    else      enable_d <= enable;
  end

  // Armed: first request after enabling counts on a low level
  always_ff @(posedge clk) begin
    if (srst || !enable) begin
      armed <= 1'b0;
    end else if (enable && !enable_d) begin
      armed <= 1'b1;
    end else if (start && edge_mode) begin
      armed <= 1'b0;
    end else if (edge_mode && req_n) begin
      armed <= 1'b1;
    end else if (!edge_mode) begin
      armed <= 1'b1;
    end
  end

  // Held request; a start clears it even against a new low sample
  always_ff @(posedge clk) begin
    if (srst || !enable) begin
      pending <= 1'b0;
    end else if (start) begin
      pending <= 1'b0;
    end else if (accept_ok && (armed || !enable_d) && !req_n) begin
      // First cycle after enabling samples before armed has settled
      pending <= 1'b1;
    end
  end

endmodule : drc_req_detect

`default_nettype wire

// File: drc_request_control.sv
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "drc_regs.svh"

module drc_request_control
  import drc_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        SRST,
  // Register port
  input  wire logic [3:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  // Transfer request pin (active low)
  input  wire logic        TRANSFER_REQUEST_INPUT_N,
  // Handshake outputs (ack and finish active low, busy active high)
  output logic             TRANSFER_ACK_OUTPUT_N,
  output logic             TRANSFER_FINISH_OUTPUT_N,
  output logic             CHANNEL_BUSY
);

  // ==========================================================
  // Registers
  // ==========================================================
  logic             ack_output_enable;
  logic             end_output_enable;
  logic             rsvd_rw;
  logic             request_sense_select;
  logic             next_request_delay;
  logic             transfer_enable_bit;
  logic             single_mode;
  logic [CNT_W-1:0] xfer_count;
  logic             channel_busy_flag;

  drc_state_e       state;
  logic [3:0]       cyc;
  logic             pending;
  logic             start;
  logic             cycle_end;
  logic             accept_ok;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic last_access(input logic [CNT_W-1:0] c);
    last_access = (c == CNT_W'(1));
  endfunction : last_access

  // Bit 28 is stored as written; software must keep it zero
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ack_output_enable    <= `DRC_MODE_RST;
      end_output_enable    <= `DRC_MODE_RST;
      rsvd_rw              <= `DRC_MODE_RST;
      request_sense_select <= `DRC_MODE_RST;
      next_request_delay   <= `DRC_MODE_RST;
    end else if (WR && hit(ADDR, `DRC_MODE_OFS)) begin
      ack_output_enable    <= WDATA[`DRC_ACK_EN_BIT];
      end_output_enable    <= WDATA[`DRC_END_EN_BIT];
      rsvd_rw              <= WDATA[`DRC_RSVD_RW_BIT];
      request_sense_select <= WDATA[`DRC_SENSE_BIT];
      next_request_delay   <= WDATA[`DRC_NRD_BIT];
    end
  end

  // Enable drops by itself when the count runs out
  always_ff @(posedge CLK) begin
    if (SRST) begin
      transfer_enable_bit <= 1'b0;
      single_mode         <= 1'b0;
    end else if (WR && hit(ADDR, `DRC_CTRL_OFS)) begin
      transfer_enable_bit <= WDATA[`DRC_TE_BIT];
      single_mode         <= WDATA[`DRC_SINGLE_BIT];
    end else if (cycle_end && last_access(xfer_count)) begin
      transfer_enable_bit <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      xfer_count <= CNT_W'(`DRC_XCNT_RST);
    end else if (WR && hit(ADDR, `DRC_XFER_OFS)) begin
      xfer_count <= WDATA[CNT_W-1:0];
    end else if (cycle_end && xfer_count != '0) begin
      xfer_count <= xfer_count - CNT_W'(1);
    end
  end

  // ==========================================================
  // Transfer sequencing
  // ==========================================================
  // Early acceptance overlaps the last cycle of the access
  assign accept_ok = transfer_enable_bit &&
                     (state == DRC_IDLE ||
                      (state == DRC_XFER && next_request_delay &&
                       cyc == `DRC_CYCLE_LEN - 4'h1));
  assign start     = state == DRC_IDLE && pending && transfer_enable_bit;
  assign cycle_end = state == DRC_XFER && cyc == `DRC_CYCLE_LEN - 4'h1;

  // DONE and the IDLE start cycle leave two dead cycles between accesses; with early
  // acceptance the next request is already held by then
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state <= DRC_IDLE;
      cyc   <= 4'h0;
    end else begin
      case (state)
        DRC_IDLE: begin
          cyc <= 4'h0;
          if (start) state <= DRC_XFER;
        end
        DRC_XFER: begin
          cyc <= cyc + 4'h1;
          if (cycle_end) state <= DRC_DONE;
        end
        DRC_DONE: begin
          cyc   <= 4'h0;
          state <= DRC_IDLE;
        end
        default: state <= DRC_IDLE;
      endcase
    end
  end

  // Edge mode: after the first request, a low sample only counts once re-armed by a high
  drc_req_detect u_detect (
    .clk       (CLK),
    .srst      (SRST),
    .enable    (transfer_enable_bit),
    .edge_mode (request_sense_select),
    .accept_ok (accept_ok),
    .req_n     (TRANSFER_REQUEST_INPUT_N),
    .start     (start),
    .pending   (pending),
    .armed     ()
  );

  // Busy while a request is held or a transfer runs
  // A held request counts as active so the flag sets on the edge the access starts, not a cycle later
  always_ff @(posedge CLK) begin
    if (SRST) channel_busy_flag <= 1'b0;
    else      channel_busy_flag <= transfer_enable_bit &&
                                   (state != DRC_IDLE || pending);
  end

  // ==========================================================
  // Pin outputs
  // ==========================================================
  // The start cycle opens the window so the registered pins line up
  // with the three access cycles of the state machine
  logic in_access;
  logic next_ack_n;
  logic next_fin_n;

  always_comb begin
    in_access  = start || (state == DRC_XFER && !cycle_end);
    next_ack_n = !(ack_output_enable && single_mode &&
                   in_access);
    next_fin_n = !(end_output_enable && in_access &&
                   last_access(xfer_count));
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      TRANSFER_ACK_OUTPUT_N    <= 1'b1;
      TRANSFER_FINISH_OUTPUT_N <= 1'b1;
      CHANNEL_BUSY             <= 1'b0;
    end else begin
      TRANSFER_ACK_OUTPUT_N    <= next_ack_n;
      TRANSFER_FINISH_OUTPUT_N <= next_fin_n;
      CHANNEL_BUSY             <= channel_busy_flag;
    end
  end

  // ==========================================================
  // Read port
  // ==========================================================
  // Read data lives one cycle only; idle cycles read zero so a
  // stale word is never taken for a fresh read
  always_ff @(posedge CLK) begin
    if (SRST) begin
      RDATA <= '0;
    end else if (RD) begin
      RDATA <= '0;
      if (hit(ADDR, `DRC_MODE_OFS)) begin
        RDATA[`DRC_ACK_EN_BIT]  <= ack_output_enable;
        RDATA[`DRC_END_EN_BIT]  <= end_output_enable;
        RDATA[`DRC_RSVD_RW_BIT] <= rsvd_rw;
        RDATA[`DRC_SENSE_BIT]   <= request_sense_select;
        RDATA[`DRC_NRD_BIT]     <= next_request_delay;
        RDATA[`DRC_BUSY_BIT]    <= channel_busy_flag;
      end else if (hit(ADDR, `DRC_CTRL_OFS)) begin
        RDATA[`DRC_TE_BIT]      <= transfer_enable_bit;
        RDATA[`DRC_SINGLE_BIT]  <= single_mode;
      end else if (hit(ADDR, `DRC_XFER_OFS)) begin
        RDATA[CNT_W-1:0]        <= xfer_count;
      end
    end else begin
      RDATA <= '0;
    end
  end

endmodule : drc_request_control

`default_nettype wire

// File: drc_periph.sv
`timescale 1ns/1ps
`default_nettype none
module drc_periph (
  // Control from the bench
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic demand,
  input  wire logic polite,
  // Pins
  input  wire logic ack_n,
  output logic      req_n
);
  // Polite mode lets the pin go high while acknowledged, re-arming edges
  always_ff @(posedge clk) begin
    if (srst || !demand) begin
      req_n <= 1'b1;
    end else begin
      req_n <= polite && !ack_n;
    end
  end
endmodule : drc_periph
`default_nettype wire

// File: drc_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "drc_regs.svh"
module drc_properties (
  // Clock, reset and register port
  input wire logic        CLK,
  input wire logic        SRST,
  input wire logic [3:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  // Pins
  input wire logic        TRANSFER_REQUEST_INPUT_N,
  input wire logic        TRANSFER_ACK_OUTPUT_N,
  input wire logic        TRANSFER_FINISH_OUTPUT_N,
  input wire logic        CHANNEL_BUSY
);
  wire logic rq = TRANSFER_REQUEST_INPUT_N;
  wire logic ak = TRANSFER_ACK_OUTPUT_N;
  wire logic fn = TRANSFER_FINISH_OUTPUT_N;
  logic      edge_sel, ack_en, single;
  // Shadow of the configuration, rebuilt from bus writes
  always_ff @(posedge CLK) begin
    if (SRST) begin
      {ack_en, edge_sel, single} <= 3'h0;
    end else if (WR && ADDR == `DRC_MODE_OFS) begin
      {ack_en, edge_sel} <= {WDATA[`DRC_ACK_EN_BIT], WDATA[`DRC_SENSE_BIT]};
    end else if (WR && ADDR == `DRC_CTRL_OFS) begin
      single <= WDATA[`DRC_SINGLE_BIT];
    end
  end
  // ====================
  // Properties
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);
  sequence s_access(x); !x [*3] ##1 x; endsequence
  // Pin stuck low across an access and well after it
  sequence s_stuck;
    !rq [*5] ##1 (edge_sel && $rose(ak) && !rq) ##1 !rq [*4];
  endsequence
  property p_ack_len; $fell(ak) |-> s_access(ak); endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack width");
  property p_fin_len; $fell(fn) |-> s_access(fn); endproperty
  a_fin_len: assert property (p_fin_len) else $error("end width");
  property p_ack_en; $fell(ak) |-> ack_en && single; endproperty
  a_ack_en: assert property (p_ack_en) else $error("ack gating");
  property p_busy; !ak && $past(!ak) |-> CHANNEL_BUSY; endproperty
  a_busy: assert property (p_busy) else $error("busy low");
  property p_rsvd;
    $past(RD) && $past(ADDR) == `DRC_MODE_OFS |-> RDATA[25:24] == 2'h0
      && RDATA[22:20] == 3'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits");
  property p_rd_idle; !$past(RD) |-> RDATA == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata idle");
  property p_rearm; s_stuck |-> ak; endproperty
  a_rearm: assert property (p_rearm) else $error("edge re-arm");
  property p_reset;
    disable iff (1'b0) SRST |=> ak && fn && !CHANNEL_BUSY && RDATA == 32'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state");
endmodule : drc_properties
bind drc_request_control drc_properties i_props (.CLK(CLK), .SRST(SRST),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .TRANSFER_REQUEST_INPUT_N(TRANSFER_REQUEST_INPUT_N),
  .TRANSFER_ACK_OUTPUT_N(TRANSFER_ACK_OUTPUT_N),
  .TRANSFER_FINISH_OUTPUT_N(TRANSFER_FINISH_OUTPUT_N),
  .CHANNEL_BUSY(CHANNEL_BUSY));
`default_nettype wire

// File: dma_request_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "drc_regs.svh"
module dma_request_control_bench
  import drc_pkg::*;
;
  typedef struct {drc_word_t mode, ctrl, ack, fin, rb;} drc_row_s;
  logic      CLK = 1'b0, SRST = 1'b1, WR = 1'b0, RD = 1'b0;
  logic      demand = 1'b0, polite = 1'b0, ack_q = 1'b1, fin_q = 1'b1;
  logic      REQ_N, ACK_N, FIN_N, BUSY;
  logic      [3:0] ADDR = 4'h0;
  drc_word_t WDATA = 32'h0, RDATA, d;
  int        error_cnt = 0, cmp_count = 0, acks = 0, fins = 0, a0, f0;
  drc_row_s  rows [6] = '{'{32'h0, 32'h3, 0, 0, 32'h0},
    '{32'h4000_0000, 32'h3, 1, 0, 32'h4000_0000},
    '{32'h4000_0000, 32'h1, 0, 0, 32'h4000_0000},
    '{32'h2000_0000, 32'h1, 0, 1, 32'h2000_0000},
    '{32'h6000_0000, 32'h3, 1, 1, 32'h6000_0000},
    '{32'h6fff_ffff, 32'h3, 1, 1, 32'h6c00_0000}};
  drc_request_control i_dut (.CLK(CLK), .SRST(SRST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .TRANSFER_REQUEST_INPUT_N(REQ_N), .TRANSFER_ACK_OUTPUT_N(ACK_N),
    .TRANSFER_FINISH_OUTPUT_N(FIN_N), .CHANNEL_BUSY(BUSY));
  drc_periph i_periph (.clk(CLK), .srst(SRST), .demand(demand),
    .polite(polite), .ack_n(ACK_N), .req_n(REQ_N));
  always #12.5 CLK = ~CLK;
  always @(posedge CLK) begin
    {ack_q, fin_q} <= {ACK_N, FIN_N};
    if (ack_q === 1'b1 && ACK_N === 1'b0) acks <= acks + 1;
    if (fin_q === 1'b1 && FIN_N === 1'b0) fins <= fins + 1;
  end
  task automatic wr(logic [3:0] a, drc_word_t v);
    @(posedge CLK);
    {ADDR, WDATA, WR} <= {a, v, 1'b1};
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(logic [3:0] a);
    @(posedge CLK);
    {ADDR, RD} <= {a, 1'b1};
    @(posedge CLK);
    RD <= 1'b0;
    @(negedge CLK) d = RDATA;
  endtask : rd
  task automatic check(string what, drc_word_t seen, drc_word_t exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Count of one access each unless the test asks for more
  task automatic setup(drc_word_t mode, drc_word_t ctrl, drc_word_t cnt);
    wr(`DRC_MODE_OFS, mode);
    wr(`DRC_XFER_OFS, cnt);
    wr(`DRC_CTRL_OFS, ctrl);
    {a0, f0} = {acks, fins};
    demand <= 1'b1;
  endtask : setup
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  initial begin
    #60000;
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge CLK);
    SRST <= 1'b0;
    foreach (rows[i]) begin
      setup(rows[i].mode, rows[i].ctrl, 32'h1);
      repeat (14) @(posedge CLK);
      demand <= 1'b0;
      check("acks", acks - a0, rows[i].ack);
      check("ends", fins - f0, rows[i].fin);
      rd(`DRC_MODE_OFS);
      check("mode", d & 32'h7ff0_0000, rows[i].rb);
      $display("row %0d done", i);
    end
    setup(32'h4000_0000, 32'h3, 32'h3);
    for (int i = 0; i < 20 && ACK_N !== 1'b0; i++) @(negedge CLK);
    rd(`DRC_MODE_OFS);
    check("active", d[23], 1'b1);
    check("busy pin", BUSY, 1'b1);
    repeat (30) @(posedge CLK);
    check("level acks", acks - a0, 3);
    demand <= 1'b0;
    $display("level burst done");
    setup(32'h6400_0000, 32'h3, 32'h3);
    repeat (15) @(posedge CLK);
    check("early acks", acks - a0, 3);
    check("early ends", fins - f0, 1);
    demand <= 1'b0;
    $display("early accept done");
    setup(32'h4800_0000, 32'h3, 32'h3);
    repeat (30) @(posedge CLK);
    check("edge held", acks - a0, 1);
    demand <= 1'b0;
    @(posedge CLK);
    {demand, polite} <= 2'b11;
    repeat (30) @(posedge CLK);
    check("edge rearm", acks - a0, 3);
    {demand, polite} <= 2'b00;
    $display("edge test done");
    wr(`DRC_MODE_OFS, 32'h4800_0000);
    wr(`DRC_XFER_OFS, 32'h1);
    demand <= 1'b1;
    wr(`DRC_CTRL_OFS, 32'h3);
    repeat (2) @(posedge CLK);
    @(negedge CLK);
    check("first sample", ACK_N, 1'b0);
    repeat (6) @(posedge CLK);
    demand <= 1'b0;
    $display("first sample done");
    setup(32'h6000_0000, 32'h3, 32'h3);
    repeat (4) @(posedge CLK);
    SRST <= 1'b1;
    repeat (2) @(posedge CLK);
    check("ack idle", ACK_N, 1'b1);
    check("busy idle", BUSY, 1'b0);
    {SRST, demand} <= 2'b00;
    rd(`DRC_MODE_OFS);
    check("mode reset", d, 32'h0);
    rd(4'hc);
    check("unmapped", d, 32'h0);
    $display("reset test done");
    summarize();
  end
endmodule : dma_request_control_bench
`default_nettype wire
